// ===== rtl/system_register_write_guard.sv
`timescale 1ns/10ps

// Functional notes
// - writing key 0x0096 to the key field removes write protection
// - writing any other key value restores write protection
// - while protected, writes to guarded bits are dropped, contents kept
// - only guarded bits are gated; other bits always take writes
// - unlocked state persists over any number of writes until relocked
// - key field is 16 bits, read/write, resets to 0x0000 so guard starts closed
module system_register_write_guard
   import system_register_write_guard_pkg::*;
#(
   parameter word_t PROT_WP_MASK = `SRWG_PCTRL_WP,
   parameter word_t WO_WP_MASK   = `SRWG_WCTRL_WP
)
(
   // clock and reset
   input  wire logic  mclk,
   input  wire logic  rst_b,
   // register port
   input  wire addr_t addr,
   input  wire word_t wrData,
   input  wire logic  wrEn,
   input  wire logic  rdEn,
   output      word_t rdData,
   // guarded control outputs
   output      word_t protCtrl,
   output      word_t woCtrl,
   // guard state
   output      logic  unlocked,
   output      logic  dropped
);

   guard_state_s st;
   guard_state_s next_st;

   word_t keyField;
   word_t statWord;

   assign keyField = st.key;
   assign rdData   = st.rdData;
   assign protCtrl = st.protCtrl;
   assign woCtrl   = st.woCtrl;
   assign unlocked = st.unlocked;
   assign dropped  = st.dropped;

   always_comb
   begin
      statWord = '0;
      statWord[`SRWG_STAT_OPEN_BIT] = st.unlocked;
      statWord[`SRWG_STAT_DROP_BIT] = st.dropped;
   end

   always_comb
   begin
      next_st = st;
      // read data lives for exactly one cycle
      next_st.rdData = '0;

      if (wrEn)
      begin
         unique case (addr)
            `SRWG_KEY_OFS:
            begin
               // key register itself is never gated
               next_st.key      = wrData;
               // open only on the exact key, anything else closes
               next_st.unlocked = (wrData == `SRWG_UNLOCK_KEY);
            end
            `SRWG_PCTRL_OFS:
            begin
               if (st.unlocked)
               begin
                  next_st.protCtrl = wrData;
               end
               else
               begin
                  // guarded bits hold, free bits follow the write
                  next_st.protCtrl = (st.protCtrl & PROT_WP_MASK)
                                   | (wrData & ~PROT_WP_MASK);
               end
            end
            `SRWG_WCTRL_OFS:
            begin
               if (st.unlocked)
               begin
                  next_st.woCtrl = wrData;
               end
               else
               begin
                  next_st.woCtrl = (st.woCtrl & WO_WP_MASK)
                                 | (wrData & ~WO_WP_MASK);
               end
            end
            `SRWG_STAT_OFS:
            begin
               // write one to clear the dropped-write flag
               if (wrData[`SRWG_STAT_DROP_BIT])
               begin
                  next_st.dropped = 1'b0;
               end
            end
            default:
            begin
               // unmapped write is ignored
            end
         endcase

         // a blocked write sets the flag; set after clear so set wins
         if (!st.unlocked
             && (((addr == `SRWG_PCTRL_OFS) && (PROT_WP_MASK != '0))
              || ((addr == `SRWG_WCTRL_OFS) && (WO_WP_MASK != '0))))
         begin
            next_st.dropped = 1'b1;
         end
      end

      if (rdEn)
      begin
         unique case (addr)
            `SRWG_KEY_OFS:
            begin
               next_st.rdData = st.key;
            end
            `SRWG_PCTRL_OFS:
            begin
               next_st.rdData = st.protCtrl;
            end
            `SRWG_WCTRL_OFS:
            begin
               // write-only guarded bits read as zero
               next_st.rdData = st.woCtrl & ~WO_WP_MASK;
            end
            `SRWG_STAT_OFS:
            begin
               next_st.rdData = statWord;
            end
            default:
            begin
               next_st.rdData = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // guard comes up closed
         st.key      <= `SRWG_KEY_RST;
         st.protCtrl <= `SRWG_PCTRL_RST;
         st.woCtrl   <= `SRWG_WCTRL_RST;
         st.unlocked <= 1'b0;
         st.dropped  <= 1'b0;
         st.rdData   <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking

   default disable iff (!rst_b);

   property p_unlock;
      wrEn && (addr == `SRWG_KEY_OFS) && (wrData == `SRWG_UNLOCK_KEY)
         |=> unlocked;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("exact key did not open the guard");

   property p_relock;
      wrEn && (addr == `SRWG_KEY_OFS) && (wrData != `SRWG_UNLOCK_KEY)
         |=> !unlocked && (keyField == $past(wrData));
   endproperty
   a_relock: assert property (p_relock)
      else $error("non-key write left the guard open");

   property p_open_matches_key;
      unlocked == (keyField == `SRWG_UNLOCK_KEY);
   endproperty
   a_open_matches_key: assert property (p_open_matches_key)
      else $error("guard state disagrees with key field");

   property p_locked_hold;
      wrEn && (addr == `SRWG_PCTRL_OFS) && !unlocked
         |=> ((protCtrl & PROT_WP_MASK) == ($past(protCtrl) & PROT_WP_MASK))
             && (dropped || (PROT_WP_MASK == '0));
   endproperty
   a_locked_hold: assert property (p_locked_hold)
      else $error("guarded bits changed while locked");

   property p_free_bits;
      wrEn && (addr == `SRWG_WCTRL_OFS)
         |=> (woCtrl & ~WO_WP_MASK) == ($past(wrData) & ~WO_WP_MASK);
   endproperty
   a_free_bits: assert property (p_free_bits)
      else $error("unguarded bits did not take the write");

   property p_open_write;
      wrEn && (addr == `SRWG_PCTRL_OFS) && unlocked
         |=> protCtrl == $past(wrData);
   endproperty
   a_open_write: assert property (p_open_write)
      else $error("open guard still blocked a write");

   property p_persist;
      unlocked && !(wrEn && (addr == `SRWG_KEY_OFS))
         |=> unlocked;
   endproperty
   a_persist: assert property (p_persist)
      else $error("guard closed without a key write");

   property p_key_readback;
      rdEn && (addr == `SRWG_KEY_OFS)
         |=> rdData == $past(keyField);
   endproperty
   a_key_readback: assert property (p_key_readback)
      else $error("key read did not return stored value");

   property p_rd_idle;
      !rdEn |=> rdData == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data held outside read slot");

   property p_locked_hold_wo;
      wrEn && (addr == `SRWG_WCTRL_OFS) && !unlocked
         |=> ((woCtrl & WO_WP_MASK) == ($past(woCtrl) & WO_WP_MASK))
             && (dropped || (WO_WP_MASK == '0));
   endproperty
   a_locked_hold_wo: assert property (p_locked_hold_wo)
      else $error("write-only guarded bits changed while locked");

   property p_free_bits_prot;
      wrEn && (addr == `SRWG_PCTRL_OFS)
         |=> (protCtrl & ~PROT_WP_MASK) == ($past(wrData) & ~PROT_WP_MASK);
   endproperty
   a_free_bits_prot: assert property (p_free_bits_prot)
      else $error("unguarded bits of first register did not take the write");

   property p_open_write_wo;
      wrEn && (addr == `SRWG_WCTRL_OFS) && unlocked
         |=> woCtrl == $past(wrData);
   endproperty
   a_open_write_wo: assert property (p_open_write_wo)
      else $error("open guard still blocked a write-only write");

   property p_ctrl_quiet;
      !(wrEn && ((addr == `SRWG_PCTRL_OFS) || (addr == `SRWG_WCTRL_OFS)))
         |=> $stable(protCtrl) && $stable(woCtrl);
   endproperty
   a_ctrl_quiet: assert property (p_ctrl_quiet)
      else $error("control register changed without a write to it");

   property p_key_store;
      wrEn && (addr == `SRWG_KEY_OFS)
         |=> keyField == $past(wrData);
   endproperty
   a_key_store: assert property (p_key_store)
      else $error("key write was blocked");

   property p_key_quiet;
      !(wrEn && (addr == `SRWG_KEY_OFS))
         |=> $stable(keyField);
   endproperty
   a_key_quiet: assert property (p_key_quiet)
      else $error("key field changed without a key write");

   property p_drop_sticky;
      dropped && !(wrEn && (addr == `SRWG_STAT_OFS) && wrData[`SRWG_STAT_DROP_BIT])
         |=> dropped;
   endproperty
   a_drop_sticky: assert property (p_drop_sticky)
      else $error("dropped-write flag cleared on its own");

   property p_drop_clear;
      wrEn && (addr == `SRWG_STAT_OFS) && wrData[`SRWG_STAT_DROP_BIT]
         |=> !dropped;
   endproperty
   a_drop_clear: assert property (p_drop_clear)
      else $error("dropped-write flag did not clear");

   property p_wo_read_zero;
      rdEn && (addr == `SRWG_WCTRL_OFS)
         |=> (rdData & WO_WP_MASK) == '0;
   endproperty
   a_wo_read_zero: assert property (p_wo_read_zero)
      else $error("write-only guarded bits did not read as zero");

   property p_ctrl_read;
      rdEn && (addr == `SRWG_PCTRL_OFS)
         |=> rdData == $past(protCtrl);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("first control register read back wrong");

   property p_stat_read;
      rdEn && (addr == `SRWG_STAT_OFS)
         |=> (rdData[`SRWG_STAT_OPEN_BIT] == $past(unlocked))
             && (rdData[`SRWG_STAT_DROP_BIT] == $past(dropped));
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status read disagrees with guard state");

endmodule : system_register_write_guard

// ===== rtl/system_register_write_guard_map.svh
`ifndef SYSTEM_REGISTER_WRITE_GUARD_MAP_SVH
`define SYSTEM_REGISTER_WRITE_GUARD_MAP_SVH

// register bus geometry
`define SRWG_ADDR_W          8
`define SRWG_DATA_W          16

// byte offsets of the 16-bit registers
`define SRWG_KEY_OFS         8'h00
`define SRWG_PCTRL_OFS       8'h02
`define SRWG_WCTRL_OFS       8'h04
`define SRWG_STAT_OFS        8'h06

// key that opens the guard
`define SRWG_UNLOCK_KEY      16'h0096

// reset values
`define SRWG_KEY_RST         16'h0000
`define SRWG_PCTRL_RST       16'h0000
`define SRWG_WCTRL_RST       16'h0000

// default guarded bit masks of the two control registers
`define SRWG_PCTRL_WP        16'hFF00
`define SRWG_WCTRL_WP        16'h00FF

// status register fields
`define SRWG_STAT_OPEN_BIT   0
`define SRWG_STAT_DROP_BIT   1

`endif

// ===== rtl/system_register_write_guard_pkg.sv
package system_register_write_guard_pkg;

`include "system_register_write_guard_map.svh"

   typedef logic [`SRWG_DATA_W-1:0] word_t;
   typedef logic [`SRWG_ADDR_W-1:0] addr_t;

   typedef struct packed
   {
      word_t key;
      word_t protCtrl;
      word_t woCtrl;
      logic  unlocked;
      logic  dropped;
      word_t rdData;
   } guard_state_s;

endpackage : system_register_write_guard_pkg

// ===== verif/tb_system_register_write_guard.sv
`timescale 1ns/10ps
`include "system_register_write_guard_map.svh"
module tb_system_register_write_guard
   import system_register_write_guard_pkg::*;
;
   logic  mclk = 1'b0;
   logic  rst_b = 1'b0;
   logic  wrEn = 1'b0;
   logic  rdEn = 1'b0;
   addr_t addr = 8'h00;
   word_t wrData = 16'h0000;
   word_t rdData, protCtrl, woCtrl;
   logic  unlocked, dropped;
   int    fail_count = 0;
   int    num_checks = 0;
   int    cycles = 0;
   integer seed = 38965;
   int    r;
   // expected register contents
   word_t key = 16'h0000;
   word_t pc = 16'h0000;
   word_t wc = 16'h0000;
   logic  drp = 1'b0;
   word_t keys [6] = '{16'h0000, 16'h0095, 16'h0097, 16'h9600, 16'h0196, 16'hFFFF};

   always #2 mclk = ~mclk;

   system_register_write_guard dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
      .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .protCtrl(protCtrl), .woCtrl(woCtrl),
      .unlocked(unlocked), .dropped(dropped));

   function automatic word_t merge(word_t old, word_t nw, word_t mask, logic open);
      return open ? nw : ((old & mask) | (nw & ~mask));
   endfunction : merge

   function automatic word_t stat_exp();
      word_t w;
      w = 16'h0000;
      w[`SRWG_STAT_OPEN_BIT] = (key == `SRWG_UNLOCK_KEY);
      w[`SRWG_STAT_DROP_BIT] = drp;
      return w;
   endfunction : stat_exp

   task automatic check(string what, word_t seen, word_t exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic chk_state();
      check("protCtrl", protCtrl, pc);
      check("woCtrl", woCtrl, wc);
      check("unlocked", word_t'(unlocked), word_t'(key == `SRWG_UNLOCK_KEY));
      check("dropped state", word_t'(dropped), word_t'(drp));
   endtask : chk_state

   task automatic wr(addr_t a, word_t d);
      logic open;
      open = (key == `SRWG_UNLOCK_KEY);
      @(posedge mclk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge mclk);
      wrEn <= 1'b0;
      case (a)
         `SRWG_KEY_OFS:   key = d;
         `SRWG_PCTRL_OFS: pc = merge(pc, d, `SRWG_PCTRL_WP, open);
         `SRWG_WCTRL_OFS: wc = merge(wc, d, `SRWG_WCTRL_WP, open);
         `SRWG_STAT_OFS:  drp = drp & ~d[`SRWG_STAT_DROP_BIT];
         default:         ;
      endcase
      if (!open && (a == `SRWG_PCTRL_OFS || a == `SRWG_WCTRL_OFS))
         drp = 1'b1;
      #1;
      chk_state();
      if (!open && (a == `SRWG_PCTRL_OFS || a == `SRWG_WCTRL_OFS))
         check("dropped", word_t'(dropped), 16'h0001);
   endtask : wr

   task automatic rd(addr_t a, word_t exp);
      @(posedge mclk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge mclk);
      rdEn <= 1'b0;
      #1;
      check("rdData", rdData, exp);
      @(posedge mclk);
      #1;
      check("rdData idle", rdData, 16'h0000);
   endtask : rd

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // generous ceiling: the sequence needs well under 3000 cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         fail_count++;
         close_out();
      end
   end

   initial
   begin
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      chk_state();
      rd(`SRWG_KEY_OFS, 16'h0000);
      $display("test reset done");
      wr(`SRWG_PCTRL_OFS, 16'hFFFF);
      wr(`SRWG_WCTRL_OFS, 16'hFFFF);
      rd(`SRWG_PCTRL_OFS, pc);
      rd(`SRWG_WCTRL_OFS, wc & ~`SRWG_WCTRL_WP);
      rd(`SRWG_STAT_OFS, stat_exp());
      wr(`SRWG_STAT_OFS, 16'h0002);
      check("dropped clear", word_t'(dropped), 16'h0000);
      $display("test locked writes done");
      wr(`SRWG_KEY_OFS, `SRWG_UNLOCK_KEY);
      repeat (6) wr(($random(seed) & 1) ? `SRWG_PCTRL_OFS : `SRWG_WCTRL_OFS,
                    word_t'($random(seed)));
      rd(`SRWG_KEY_OFS, `SRWG_UNLOCK_KEY);
      rd(`SRWG_STAT_OFS, stat_exp());
      $display("test unlock done");
      // reset while open must close the guard and clear the registers
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      key = 16'h0000;
      pc = 16'h0000;
      wc = 16'h0000;
      drp = 1'b0;
      #1;
      chk_state();
      rd(`SRWG_KEY_OFS, 16'h0000);
      $display("test mid reset done");
      foreach (keys[i])
      begin
         wr(`SRWG_KEY_OFS, `SRWG_UNLOCK_KEY);
         wr(`SRWG_KEY_OFS, keys[i]);
         wr(`SRWG_PCTRL_OFS, ~pc);
         rd(`SRWG_KEY_OFS, keys[i]);
      end
      $display("test relock done");
      wr(8'h10, 16'hFFFF);
      rd(8'h10, 16'h0000);
      $display("test unmapped done");
      repeat (200)
      begin
         r = $random(seed);
         case (r[1:0])
            2'h0: wr(`SRWG_KEY_OFS, r[2] ? `SRWG_UNLOCK_KEY : word_t'($random(seed)));
            2'h1: wr(`SRWG_PCTRL_OFS, word_t'($random(seed)));
            2'h2: wr(`SRWG_WCTRL_OFS, word_t'($random(seed)));
            default: rd(`SRWG_KEY_OFS, key);
         endcase
      end
      wr(`SRWG_KEY_OFS, 16'h0000);
      $display("test random done");
      close_out();
   end
endmodule : tb_system_register_write_guard
